// ===== shared/tk_consts.svh
// offsets, field positions, reset values and timing counts of the timekeeper
`ifndef TK_CONSTS_SVH
`define TK_CONSTS_SVH
// register indices
`define IDX_HUND 4'h0
`define IDX_SEC 4'h1
`define IDX_MIN 4'h2
`define IDX_AMIN 4'h3
`define IDX_HOUR 4'h4
`define IDX_AHOUR 4'h5
`define IDX_DAY 4'h6
`define IDX_ADAY 4'h7
`define IDX_DATE 4'h8
`define IDX_MONTH 4'h9
`define IDX_YEAR 4'ha
`define IDX_CMD 4'hb
`define IDX_WDOG_LO 4'hc
`define IDX_WDOG_HI 4'hd
`define IDX_USER_BASE 6'h0e
`define IDX_LAST 6'h3f
`define COPY_COUNT 14
// field positions
`define HOUR_12_BIT 6
`define HOUR_PM_BIT 5
`define CMD_ALARM_FLAG 0
`define CMD_SEC_HIGH 1
`define CMD_SEC_EN 2
// reset values
`define CMD_RESET 8'h00
`define ONE_RESET 8'h01
// timing
`define CLK_HZ 10000000
`define XTAL_HZ 17'd32768
`define TICK_HZ 17'd100
`define RESUME_DELAY_US 200
`define RESUME_CYCLES (`RESUME_DELAY_US * (`CLK_HZ / 1000000))
`define OUTPUT_OFF_DELAY_NS 100
`define OUTPUT_OFF_CYCLES ((`OUTPUT_OFF_DELAY_NS * (`CLK_HZ / 1000000)) / 1000)
`endif

// ===== shared/tk_pkg.sv
// types shared by the timekeeper port
package tk_pkg;
    typedef logic [7:0] byte_t;
    typedef logic [5:0] index_t;
    typedef enum logic [1:0] {ST_BLOCKED, ST_IDLE, ST_WRITE} port_state_t;
endpackage

// ===== core/tk_port.sv
// byte-wide static-ram-style timekeeper register port with calendar
`timescale 1ns/1ps
`include "tk_consts.svh"

// How it works
// - with write high and select, gate low, the selected byte is driven out.
// - six index inputs pick one of 64 byte registers per access.
// - write mode when select and write strobe are both low.
// - write cycle starts at the later falling edge of select or strobe.
// - write ends at first rising edge; data captured against that edge.
// - falling write strobe turns the data outputs off after a fixed delay.
// - supply below trip level write-protects and ignores all access inputs.
// - both interrupt pins are open drain in active-low mode and keep working without supply.
// - secondary interrupt in active-high mode drives high only with supply.
// - access resumes only after supply stays good for the resume delay.
// - time registers have internal and host copies, refreshed all at once.
// - command register bits are changed by hardware and by host writes.
// - fifty user bytes are reached only from the host bus.
// - time and date sit in BCD at indices 0,1,2,4,6,8,9,a.
// - time-of-day alarm sits in BCD at indices 3,5,7.
// - watchdog alarm values sit in BCD at indices c and d.
// - indices e to 3f are plain user storage.
// - the date rolls over at short month ends, leap years included.
// - hours run in 24-hour or 12-hour format with am/pm.
// - the time base comes from the 32.768 kHz crystal clock.
module tk_port (
    // clock and reset
    input wire logic CLK_I,
    input wire logic RESET_I,
    // register port
    input wire tk_pkg::index_t REG_INDEX_I,
    input wire logic SEL_N_I,
    input wire logic GATE_N_I,
    input wire logic WRITE_N_I,
    input wire tk_pkg::byte_t BIDIR_BYTE_I,
    output tk_pkg::byte_t BIDIR_BYTE_O,
    output logic BIDIR_BYTE_OE_O,
    // supply and time base
    input wire logic SUPPLY_OK_I,
    input wire logic XTAL_I,
    // interrupt pins
    output logic IRQ_PRIMARY_N_O,
    output logic IRQ_PRIMARY_N_OE_O,
    output logic IRQ_SECONDARY_O,
    output logic IRQ_SECONDARY_OE_O
);
    import tk_pkg::*;

    // ********************************
    // bcd helpers
    // ********************************
    function automatic byte_t bcd_inc(input byte_t v);
        bcd_inc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : v + 8'h01;
    endfunction

    // leap when the BCD year is a multiple of four
    function automatic logic is_leap(input byte_t y);
        is_leap = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6)
                       : (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
    endfunction

    function automatic byte_t last_date(input byte_t mo, input byte_t y);
        if (mo == 8'h02) begin
            last_date = is_leap(y) ? 8'h29 : 8'h28;
        end else if (mo == 8'h04 || mo == 8'h06 || mo == 8'h09 || mo == 8'h11) begin
            last_date = 8'h30;
        end else begin
            last_date = 8'h31;
        end
    endfunction

    // ********************************
    // storage
    // ********************************
    byte_t mem_reg [0:63];
    byte_t tm_reg [0:`COPY_COUNT-1];
    byte_t tm_next [0:`COPY_COUNT-1];
    port_state_t state_reg;
    port_state_t state_next;
    index_t idx_reg;
    byte_t data_reg;
    byte_t rd_data_reg;
    logic oe_reg;
    logic xtal_reg;
    logic [16:0] frac_reg;
    logic xfer_pend_reg;
    logic [11:0] resume_reg;

    // ********************************
    // supply watch
    // ********************************
    wire logic supply_good;
    wire logic resume_done;
    assign resume_done = (resume_reg == 12'(`RESUME_CYCLES));
    assign supply_good = SUPPLY_OK_I && resume_done;

    // resume counter restarts on every supply drop
    always_ff @(posedge CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            resume_reg <= 12'h000;
        end else if (!SUPPLY_OK_I) begin
            resume_reg <= 12'h000;
        end else if (!resume_done) begin
            resume_reg <= resume_reg + 12'h001;
        end
    end

    // ********************************
    // write sequencing
    // ********************************
    wire logic both_low;
    wire logic write_end;
    wire logic commit;
    assign both_low = !SEL_N_I && !WRITE_N_I;
    assign write_end = SEL_N_I || WRITE_N_I;
    assign commit = (state_reg == ST_WRITE) && write_end && supply_good;

    // state of the write port
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ST_BLOCKED: if (supply_good) state_next = ST_IDLE;
            ST_IDLE: begin
                if (!supply_good) begin
                    state_next = ST_BLOCKED;
                end else if (both_low) begin
                    state_next = ST_WRITE;
                end
            end
            ST_WRITE: begin
                if (!supply_good) begin
                    state_next = ST_BLOCKED;
                end else if (write_end) begin
                    state_next = ST_IDLE;
                end
            end
        endcase
    end

    // index and data follow the bus while writing
    always_ff @(posedge CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            state_reg <= ST_BLOCKED;
            idx_reg <= 6'h00;
            data_reg <= 8'h00;
        end else begin
            state_reg <= state_next;
            if (state_next == ST_WRITE) begin
                idx_reg <= REG_INDEX_I;
                data_reg <= BIDIR_BYTE_I;
            end
        end
    end

    // ********************************
    // read path
    // ********************************
    wire logic read_cond;
    assign read_cond = supply_good && !SEL_N_I && !GATE_N_I && WRITE_N_I;

    // output held one cycle, so a falling strobe turns it off a cycle later
    always_ff @(posedge CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            oe_reg <= 1'b0;
            rd_data_reg <= 8'h00;
        end else begin
            oe_reg <= read_cond;
            rd_data_reg <= mem_reg[REG_INDEX_I];
        end
    end
    assign BIDIR_BYTE_O = rd_data_reg;
    assign BIDIR_BYTE_OE_O = oe_reg;

    // ********************************
    // time base
    // ********************************
    wire logic xtal_rise;
    wire logic [16:0] frac_sum;
    wire logic tick;
    assign xtal_rise = XTAL_I && !xtal_reg;
    assign frac_sum = frac_reg + `TICK_HZ;
    assign tick = xtal_rise && (frac_sum >= `XTAL_HZ);

    // hundredths from crystal edges, fractional accumulation
    always_ff @(posedge CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            xtal_reg <= 1'b0;
            frac_reg <= 17'h00000;
        end else begin
            xtal_reg <= XTAL_I;
            if (xtal_rise) begin
                frac_reg <= tick ? frac_sum - `XTAL_HZ : frac_sum;
            end
        end
    end

    // ********************************
    // calendar
    // ********************************
    wire byte_t hr;
    wire logic h12;
    wire logic c_hund;
    wire logic c_sec;
    wire logic c_min;
    wire logic c_hour;
    wire logic c_date;
    wire logic c_month;
    assign hr = tm_reg[`IDX_HOUR];
    assign h12 = hr[`HOUR_12_BIT];
    assign c_hund = (tm_reg[`IDX_HUND] == 8'h99);
    assign c_sec = c_hund && (tm_reg[`IDX_SEC] == 8'h59);
    assign c_min = c_sec && (tm_reg[`IDX_MIN] == 8'h59);
    assign c_hour = c_min && (h12 ? (hr[`HOUR_PM_BIT] && hr[4:0] == 5'h11)
                                  : (hr[5:0] == 6'h23));
    assign c_date = c_hour && (tm_reg[`IDX_DATE] ==
                    last_date(tm_reg[`IDX_MONTH], tm_reg[`IDX_YEAR]));
    assign c_month = c_date && (tm_reg[`IDX_MONTH] == 8'h12);

    // next internal values, carried one field into the next
    always_comb begin
        for (int i = 0; i < `COPY_COUNT; i++) begin
            tm_next[i] = tm_reg[i];
        end
        tm_next[`IDX_HUND] = c_hund ? 8'h00 : bcd_inc(tm_reg[`IDX_HUND]);
        if (c_hund) begin
            tm_next[`IDX_SEC] = (tm_reg[`IDX_SEC] == 8'h59) ? 8'h00
                                : bcd_inc(tm_reg[`IDX_SEC]);
        end
        if (c_sec) begin
            tm_next[`IDX_MIN] = (tm_reg[`IDX_MIN] == 8'h59) ? 8'h00
                                : bcd_inc(tm_reg[`IDX_MIN]);
        end
        if (c_min) begin
            if (!h12) begin
                tm_next[`IDX_HOUR] = (hr[5:0] == 6'h23) ? 8'h00 : bcd_inc(hr);
            end else if (hr[4:0] == 5'h12) begin
                tm_next[`IDX_HOUR] = {hr[7:5], 5'h01};
            end else if (hr[4:0] == 5'h11) begin
                tm_next[`IDX_HOUR] = {hr[7:6], ~hr[5], 5'h12};
            end else begin
                tm_next[`IDX_HOUR] = {hr[7:5], 5'(bcd_inc({3'h0, hr[4:0]}))};
            end
        end
        if (c_hour) begin
            tm_next[`IDX_DAY] = (tm_reg[`IDX_DAY] == 8'h07) ? 8'h01
                                : bcd_inc(tm_reg[`IDX_DAY]);
            tm_next[`IDX_DATE] = c_date ? 8'h01 : bcd_inc(tm_reg[`IDX_DATE]);
        end
        if (c_date) begin
            tm_next[`IDX_MONTH] = c_month ? 8'h01 : bcd_inc(tm_reg[`IDX_MONTH]);
        end
        if (c_month) begin
            tm_next[`IDX_YEAR] = (tm_reg[`IDX_YEAR] == 8'h99) ? 8'h00
                                 : bcd_inc(tm_reg[`IDX_YEAR]);
        end
    end

    // alarm fires as the minute changes to the stored alarm time
    wire logic alarm_hit;
    assign alarm_hit = tick && c_sec && (tm_next[`IDX_MIN] == tm_reg[`IDX_AMIN])
                       && (tm_next[`IDX_HOUR] == tm_reg[`IDX_AHOUR])
                       && (tm_next[`IDX_DAY] == tm_reg[`IDX_ADAY]);

    // ********************************
    // internal copies
    // ********************************
    wire logic host_tm;
    assign host_tm = commit && (idx_reg < 6'(`COPY_COUNT))
                     && (idx_reg != {2'b00, `IDX_CMD});

    // timekeeping runs whatever the supply does
    generate
        for (genvar g = 0; g < `COPY_COUNT; g++) begin : g_copy
            always_ff @(posedge CLK_I or posedge RESET_I) begin
                if (RESET_I) begin
                    tm_reg[g] <= (g == `IDX_DAY || g == `IDX_DATE || g == `IDX_MONTH)
                                 ? `ONE_RESET : 8'h00;
                end else if (host_tm && idx_reg == 6'(g)) begin
                    tm_reg[g] <= data_reg;
                end else if (tick) begin
                    tm_reg[g] <= tm_next[g];
                end
            end
        end
    endgenerate

    // ********************************
    // host copies
    // ********************************
    wire logic xfer;
    assign xfer = xfer_pend_reg && SEL_N_I && !commit && state_reg != ST_WRITE;

    // refresh waits for a quiet bus, then copies all at once
    always_ff @(posedge CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            xfer_pend_reg <= 1'b0;
        end else if (tick) begin
            xfer_pend_reg <= 1'b1;
        end else if (xfer) begin
            xfer_pend_reg <= 1'b0;
        end
    end

    // host-visible bytes; user bytes are written only from the bus
    always_ff @(posedge CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            for (int i = 0; i < 64; i++) begin
                mem_reg[i] <= (i == `IDX_DAY || i == `IDX_DATE || i == `IDX_MONTH)
                              ? `ONE_RESET : 8'h00;
            end
            mem_reg[`IDX_CMD] <= `CMD_RESET;
        end else begin
            if (xfer) begin
                for (int i = 0; i < `COPY_COUNT; i++) begin
                    if (i != `IDX_CMD) begin
                        mem_reg[i] <= tm_reg[i];
                    end
                end
            end
            if (commit) begin
                mem_reg[idx_reg] <= data_reg;
            end
            if (alarm_hit) begin
                // set wins over a host write in the same cycle
                mem_reg[`IDX_CMD][`CMD_ALARM_FLAG] <= 1'b1;
            end
        end
    end

    // ********************************
    // interrupt pins
    // ********************************
    wire byte_t cmd;
    wire logic sec_act;
    assign cmd = mem_reg[`IDX_CMD];
    assign sec_act = cmd[`CMD_ALARM_FLAG] && cmd[`CMD_SEC_EN];
    assign IRQ_PRIMARY_N_O = 1'b0;
    assign IRQ_PRIMARY_N_OE_O = cmd[`CMD_ALARM_FLAG];
    assign IRQ_SECONDARY_O = cmd[`CMD_SEC_HIGH];
    assign IRQ_SECONDARY_OE_O = sec_act && (!cmd[`CMD_SEC_HIGH] || SUPPLY_OK_I);

    // ********************************
    // assertions
    // ********************************
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (RESET_I);

    sequence s_write_open;
        supply_good && state_reg == ST_IDLE && both_low;
    endsequence
    sequence s_write_close;
        state_reg == ST_WRITE && write_end && supply_good;
    endsequence

    property p_read_drive;
        read_cond |=> BIDIR_BYTE_OE_O && BIDIR_BYTE_O == mem_reg[$past(REG_INDEX_I)];
    endproperty
    a_read_drive: assert property (p_read_drive) else $error("read not driven");

    property p_write_off;
        $fell(WRITE_N_I) |=> !BIDIR_BYTE_OE_O;
    endproperty
    a_write_off: assert property (p_write_off) else $error("outputs stay on");

    property p_supply_block;
        !SUPPLY_OK_I |=> !BIDIR_BYTE_OE_O && state_reg == ST_BLOCKED;
    endproperty
    a_supply_block: assert property (p_supply_block) else $error("not protected");

    property p_write_start;
        s_write_open |=> state_reg == ST_WRITE;
    endproperty
    a_write_start: assert property (p_write_start) else $error("write not started");

    property p_write_commit;
        s_write_close ##0 !alarm_hit |=> mem_reg[$past(idx_reg)] == $past(data_reg);
    endproperty
    a_write_commit: assert property (p_write_commit) else $error("write lost");

    property p_resume;
        $rose(SUPPLY_OK_I) |-> !supply_good [*8];
    endproperty
    a_resume: assert property (p_resume) else $error("resumed too early");

    property p_sec_high;
        IRQ_SECONDARY_OE_O && IRQ_SECONDARY_O |-> SUPPLY_OK_I;
    endproperty
    a_sec_high: assert property (p_sec_high) else $error("high without supply");

    property p_bcd_digit;
        tm_reg[`IDX_HUND][3:0] <= 4'h9 && tm_reg[`IDX_SEC][3:0] <= 4'h9;
    endproperty
    a_bcd_digit: assert property (p_bcd_digit) else $error("bad bcd digit");

    property p_transfer;
        xfer && !commit |=> mem_reg[`IDX_SEC] == $past(tm_reg[`IDX_SEC]);
    endproperty
    a_transfer: assert property (p_transfer) else $error("copy not refreshed");

    property p_flag_set;
        alarm_hit |=> mem_reg[`IDX_CMD][`CMD_ALARM_FLAG] ##0 IRQ_PRIMARY_N_OE_O;
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("alarm flag lost");
endmodule

// ===== testbench/tk_host_model.sv
// host processor model for the byte-wide timekeeper register port
`timescale 1ns/1ps
module tk_host_model (
    // clock
    input wire logic clk_i,
    // bus pins driven by the host
    output tk_pkg::index_t index_o,
    output logic sel_n_o,
    output logic gate_n_o,
    output logic write_n_o,
    output tk_pkg::byte_t data_o,
    // resolved data wire and device enable
    input wire tk_pkg::byte_t wire_i,
    input wire logic dev_oe_i
);
    import tk_pkg::*;

    // ****************
    // idle bus at time zero
    // ****************
    initial begin
        index_o = 6'h00;
        sel_n_o = 1'b1;
        gate_n_o = 1'b1;
        write_n_o = 1'b1;
        data_o = 8'h00;
    end

    // one write; sel_first makes select lead and end the cycle
    task automatic write_reg(input index_t idx, input byte_t val, input logic sel_first);
        @(negedge clk_i);
        index_o = idx;
        data_o = val;
        gate_n_o = 1'b1;
        if (sel_first) sel_n_o = 1'b0;
        else write_n_o = 1'b0;
        @(negedge clk_i);
        sel_n_o = 1'b0;
        write_n_o = 1'b0;
        @(negedge clk_i);
        if (sel_first) sel_n_o = 1'b1;
        else write_n_o = 1'b1;
        @(negedge clk_i);
        sel_n_o = 1'b1;
        write_n_o = 1'b1;
        @(negedge clk_i);
        data_o = ~val; // released wire stops showing the byte
        @(negedge clk_i);
    endtask

    // one read; seen stays low when the device never drives
    task automatic read_reg(input index_t idx, output byte_t val, output logic seen);
        int n;
        @(negedge clk_i);
        index_o = idx;
        sel_n_o = 1'b0;
        gate_n_o = 1'b0;
        seen = 1'b0;
        val = 8'h00;
        for (n = 0; n < 4 && !seen; n++) begin
            @(negedge clk_i);
            if (dev_oe_i === 1'b1) begin
                @(negedge clk_i); // let the byte of this index land
                val = wire_i;
                seen = 1'b1;
            end
        end
        sel_n_o = 1'b1;
        gate_n_o = 1'b1;
        @(negedge clk_i);
    endtask

    // read, then pull the write strobe low with the gate still low
    task automatic strobe_in_read(input index_t idx, input byte_t val, output int lag);
        @(negedge clk_i);
        index_o = idx;
        sel_n_o = 1'b0;
        gate_n_o = 1'b0;
        repeat (3) @(negedge clk_i);
        data_o = val;
        write_n_o = 1'b0;
        lag = 0;
        while (lag < 4 && dev_oe_i !== 1'b0) begin
            @(negedge clk_i);
            lag++;
        end
        @(negedge clk_i); // sample our byte, not the device's
        write_n_o = 1'b1;
        sel_n_o = 1'b1;
        gate_n_o = 1'b1;
        @(negedge clk_i);
        data_o = ~val;
        @(negedge clk_i);
    endtask
endmodule

// ===== testbench/tb_sram_style_timekeeper_port.sv
// self-checking bench for the timekeeper register port
`timescale 1ns/1ps
module tb_sram_style_timekeeper_port;
    import tk_pkg::*;

    // ****************
    // signals
    // ****************
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic supply_ok = 1'b1;
    logic xtal = 1'b0;
    logic xtal_run = 1'b0;
    logic [1:0] xt_cnt = 2'h0;
    index_t index;
    logic sel_n, gate_n, write_n, dev_oe;
    byte_t host_data, dev_data, bus_wire;
    logic irq_p, irq_p_oe, irq_s, irq_s_oe;
    int err_total = 0;
    int samples_checked = 0;
    localparam byte_t RST_VALS [14] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01,
        8'h00, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00};
    localparam index_t USER_IDX [6] = '{6'h0e, 6'h0f, 6'h1f, 6'h20, 6'h3e, 6'h3f};

    // data wire: device byte while it drives, else the host side
    assign bus_wire = (dev_oe === 1'b1) ? dev_data : host_data;

    // clock
    initial begin
        forever #50 clk = ~clk;
    end

    // fast crystal stand-in, still only while a test lets it run
    always @(negedge clk) begin
        xt_cnt <= xt_cnt + 2'h1;
        xtal <= xtal_run & xt_cnt[1];
    end

    // ****************
    // instances
    // ****************
    tk_port tk_port_i (.CLK_I(clk), .RESET_I(rst), .REG_INDEX_I(index), .SEL_N_I(sel_n),
        .GATE_N_I(gate_n), .WRITE_N_I(write_n), .BIDIR_BYTE_I(bus_wire),
        .BIDIR_BYTE_O(dev_data), .BIDIR_BYTE_OE_O(dev_oe), .SUPPLY_OK_I(supply_ok),
        .XTAL_I(xtal), .IRQ_PRIMARY_N_O(irq_p), .IRQ_PRIMARY_N_OE_O(irq_p_oe),
        .IRQ_SECONDARY_O(irq_s), .IRQ_SECONDARY_OE_O(irq_s_oe));
    tk_host_model tk_host_model_i (.clk_i(clk), .index_o(index), .sel_n_o(sel_n),
        .gate_n_o(gate_n), .write_n_o(write_n), .data_o(host_data), .wire_i(bus_wire),
        .dev_oe_i(dev_oe));

    // ****************
    // helpers
    // ****************
    task automatic check(input byte_t got, input byte_t exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // interrupt pins packed as {pin_a, pin_a_oe, pin_b, pin_b_oe}
    task automatic pin_check(input byte_t exp);
        check({4'h0, irq_p, irq_p_oe, irq_s, irq_s_oe}, exp);
    endtask

    // read one byte and compare it
    task automatic rd_check(input index_t idx, input byte_t exp);
        byte_t v;
        logic s;
        tk_host_model_i.read_reg(idx, v, s);
        check({7'h00, s}, 8'h01);
        if (s) check(v, exp);
    endtask

    task automatic test_done;
        $display("counts: %0d compared, %0d mismatched", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    // ****************
    // scenarios
    // ****************
    task automatic t_reset_values;
        for (int i = 0; i < 14; i++) rd_check(6'(i), RST_VALS[i]);
        rd_check(6'h0e, 8'h00);
        rd_check(6'h3f, 8'h00);
        pin_check(8'h00);
        $display("test reset values done");
    endtask

    // user bytes at the region edges, both strobe orders
    task automatic t_user_map;
        for (int i = 0; i < 6; i++) tk_host_model_i.write_reg(USER_IDX[i],
            8'ha5 ^ {2'h0, USER_IDX[i]}, 1'(i));
        for (int i = 0; i < 6; i++) rd_check(USER_IDX[i], 8'ha5 ^ {2'h0, USER_IDX[i]});
        $display("test user map done");
    endtask

    task automatic t_strobe_off;
        int lag;
        tk_host_model_i.strobe_in_read(6'h15, 8'h3c, lag);
        check({7'h00, lag >= 1 && lag <= 2}, 8'h01);
        rd_check(6'h15, 8'h3c);
        $display("test strobe off done");
    endtask

    // supply loss blocks access, resume waits the full delay
    task automatic t_supply;
        byte_t v;
        logic s;
        // flag, active-high mode and enable set from the bus
        tk_host_model_i.write_reg(6'h0b, 8'h07, 1'b1);
        pin_check(8'h07);
        rd_check(6'h0b, 8'h07);
        @(negedge clk);
        supply_ok = 1'b0;
        tk_host_model_i.write_reg(6'h0e, 8'h77, 1'b0);
        pin_check(8'h06);
        tk_host_model_i.read_reg(6'h0e, v, s);
        check({7'h00, s}, 8'h00);
        supply_ok = 1'b1;
        repeat (1900) @(negedge clk);
        tk_host_model_i.read_reg(6'h0e, v, s);
        check({7'h00, s}, 8'h00);
        repeat (150) @(negedge clk);
        rd_check(6'h0e, 8'ha5 ^ 8'h0e);
        tk_host_model_i.write_reg(6'h0b, 8'h00, 1'b0);
        pin_check(8'h00);
        $display("test supply done");
    endtask

    // load 23:59:59.99-style time, let one tick pass, check the carries
    task automatic run_tick(input byte_t hr, input byte_t dt, input byte_t yr,
            input byte_t e_hr, input byte_t e_dt, input byte_t e_mo);
        tk_host_model_i.write_reg(6'h00, 8'h99, 1'b0);
        tk_host_model_i.write_reg(6'h01, 8'h59, 1'b1);
        tk_host_model_i.write_reg(6'h02, 8'h59, 1'b0);
        tk_host_model_i.write_reg(6'h04, hr, 1'b1);
        tk_host_model_i.write_reg(6'h08, dt, 1'b0);
        tk_host_model_i.write_reg(6'h09, 8'h02, 1'b1);
        tk_host_model_i.write_reg(6'h0a, yr, 1'b0);
        @(negedge clk);
        xtal_run = 1'b1;
        repeat (1400) @(negedge clk); // one tick: 350 rising crystal edges, at most 328 needed
        xtal_run = 1'b0;
        repeat (4) @(negedge clk);
        rd_check(6'h00, 8'h00);
        rd_check(6'h01, 8'h00);
        rd_check(6'h02, 8'h00);
        rd_check(6'h04, e_hr);
        rd_check(6'h08, e_dt);
        rd_check(6'h09, e_mo);
    endtask

    task automatic t_calendar;
        // alarm at 00:00 of day 02, the first rollover below
        tk_host_model_i.write_reg(6'h07, 8'h02, 1'b0);
        tk_host_model_i.write_reg(6'h0c, 8'h42, 1'b1);
        run_tick(8'h23, 8'h28, 8'h01, 8'h00, 8'h01, 8'h03);
        rd_check(6'h0b, 8'h01);
        pin_check(8'h04);
        run_tick(8'h23, 8'h28, 8'h04, 8'h00, 8'h29, 8'h02);
        run_tick(8'h51, 8'h10, 8'h01, 8'h72, 8'h10, 8'h02);
        rd_check(6'h0c, 8'h42);
        $display("test calendar done");
    endtask

    // ****************
    // main sequence and hang guard
    // ****************
    initial begin
        repeat (3) @(negedge clk);
        rst = 1'b0;
        repeat (2010) @(negedge clk);
        t_reset_values();
        t_user_map();
        t_strobe_off();
        t_supply();
        t_calendar();
        test_done();
    end

    initial begin
        #(100 * 60000);
        err_total++;
        test_done();
    end
endmodule
